// *** hdl/ifs_map.vh ***
// Register addresses, field positions, reset values and sizes of the status block
`ifndef IFS_MAP_VH
`define IFS_MAP_VH

`define IFS_RAW_IRQ_STATUS_ADDR 32'h50001334
`define IFS_RX_FIFO_THRESHOLD_ADDR 32'h50001338
`define IFS_TX_FIFO_THRESHOLD_ADDR 32'h5000133c
`define IFS_CLEAR_ALL_IRQS_ADDR 32'h50001340

`define IFS_BIT_RX_UNDER 0
`define IFS_BIT_RX_OVER 1
`define IFS_BIT_RX_FULL 2
`define IFS_BIT_TX_OVER 3
`define IFS_BIT_TX_EMPTY 4

`define IFS_FIFO_DEPTH 6'h20
`define IFS_THRESHOLD_MAX 5'h1f
`define IFS_THRESHOLD_RESET 5'h00
`define IFS_ABORT_KEEP_BIT 9

`endif

// *** hdl/ifs_fifo_level.v ***
// Fill-level tracker for one 32-entry FIFO, with flush
`timescale 1ns/1ns
module ifs_fifo_level (
    clk_sys, // System clock
    resetn, // Asynchronous reset, active low
    flush, // Hold level at zero
    push, // Entry written
    pop, // Entry taken
    level, // Current fill level
    full, // Level equals depth
    empty // Level is zero
);
`include "ifs_map.vh"
    input wire clk_sys;
    input wire resetn;
    input wire flush;
    input wire push;
    input wire pop;
    output reg [5:0] level;
    output wire full;
    output wire empty;

    wire doPush;
    wire doPop;

    assign full = (level == `IFS_FIFO_DEPTH);
    assign empty = (level == 6'h00);
    // A push into a full FIFO is dropped, a pop of an empty one does nothing
    assign doPush = push & ~full;
    assign doPop = pop & ~empty;

    // Level counter; flush beats any traffic
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            level <= 6'h00;
        end else if (flush) begin
            level <= 6'h00;
        end else if (doPush & ~doPop) begin
            level <= level + 6'h01;
        end else if (doPop & ~doPush) begin
            level <= level - 6'h01;
        end
    end
endmodule // ifs_fifo_level

// *** hdl/ifs_status.v ***
// FIFO threshold registers and raw interrupt status of the I2C controller
`timescale 1ns/1ns
module ifs_status (
    clk_sys, // System clock, 20 MHz
    resetn, // Asynchronous reset, active low
    psel, // APB select
    penable, // APB enable
    pwrite, // APB write
    paddr, // APB byte address
    pwdata, // APB write data
    prdata, // APB read data
    pready, // APB ready
    pslverr, // APB error for unmapped address
    ctrlEnable, // Controller enable bit from the enable register
    engineActive, // Master or slave state machine not idle
    dataCmdWrite, // Processor write to data_command_port
    dataCmdRead, // Processor read of data_command_port
    txPop, // Engine takes a transmit entry
    rxByte, // Engine delivers a received byte
    abortCauseKeep, // Bit 9 of abort_cause_reg
    irqMask, // Mask bits for the five flags, 1 enables
    internalEnable, // Internal enable
    rawIrqStatus, // Raw flags, bits 4:0
    abortCauseClear, // Pulse: clear abort_cause_reg
    irqCombined // Combined interrupt
);
`include "ifs_map.vh"
    input wire clk_sys;
    input wire resetn;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [31:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output reg pready;
    output reg pslverr;
    input wire ctrlEnable;
    input wire engineActive;
    input wire dataCmdWrite;
    input wire dataCmdRead;
    input wire txPop;
    input wire rxByte;
    input wire abortCauseKeep;
    input wire [4:0] irqMask;
    output reg internalEnable;
    output reg [4:0] rawIrqStatus;
    output reg abortCauseClear;
    output reg irqCombined;

    reg [4:0] rxThreshold_reg;
    reg [4:0] txThreshold_reg;
    // Next raw flags and the two FIFO fill levels
    reg [4:0] raw_next;
    wire [5:0] rxLevel;
    wire [5:0] txLevel;
    wire rxFull;
    wire txFull;
    wire rxEmpty;
    // Bus decode and completion strobes
    wire accessDone;
    wire wrDone;
    wire rdDone;
    wire hitRaw;
    wire hitRxTl;
    wire hitTxTl;
    wire hitClr;
    wire clearAll;
    wire [4:0] thrWrite;

    // Access completes on the second APB access cycle, when pready is high
    assign accessDone = psel & penable & pready;
    assign wrDone = accessDone & pwrite;
    assign rdDone = accessDone & ~pwrite;

    // Full-width address decode; anything else is refused with pslverr
    assign hitRaw = (paddr == `IFS_RAW_IRQ_STATUS_ADDR);
    assign hitRxTl = (paddr == `IFS_RX_FIFO_THRESHOLD_ADDR);
    assign hitTxTl = (paddr == `IFS_TX_FIFO_THRESHOLD_ADDR);
    assign hitClr = (paddr == `IFS_CLEAR_ALL_IRQS_ADDR);

    // Clear-all acts on the completing read only, never on the wait cycle
    assign clearAll = rdDone & hitClr;
    // Writes with any of bits 15:5 set saturate to the deepest setting
    assign thrWrite = (pwdata[15:5] != 11'h000) ? `IFS_THRESHOLD_MAX : pwdata[4:0];

    // Pops of an empty FIFO are ignored here; the underflow flag records them
    // Receive FIFO level, flushed while the enable bit is zero
    ifs_fifo_level rxFifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .flush(~ctrlEnable),
        .push(rxByte),
        .pop(dataCmdRead),
        .level(rxLevel),
        .full(rxFull),
        .empty(rxEmpty)
    );

    // Transmit FIFO level, flushed while the enable bit is zero
    ifs_fifo_level txFifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .flush(~ctrlEnable),
        .push(dataCmdWrite),
        .pop(txPop),
        .level(txLevel),
        .full(txFull),
        .empty()
    );

    // Internal enable stays up after disable until the engines go idle
    // Sticky flags survive a disable for as long as this stays high
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            internalEnable <= 1'b0;
        end else begin
            internalEnable <= ctrlEnable | (internalEnable & engineActive);
        end
    end

    // Next raw flags; events win over a clear-all in the same cycle
    always @* begin
        raw_next = rawIrqStatus;
        if (clearAll) begin
            raw_next[`IFS_BIT_RX_UNDER] = 1'b0;
            raw_next[`IFS_BIT_RX_OVER] = 1'b0;
            raw_next[`IFS_BIT_TX_OVER] = 1'b0;
        end
        if (!internalEnable) begin
            raw_next[`IFS_BIT_RX_UNDER] = 1'b0;
            raw_next[`IFS_BIT_RX_OVER] = 1'b0;
            raw_next[`IFS_BIT_TX_OVER] = 1'b0;
        end
        // Overflow and underflow events come last so that a set wins
        if (dataCmdWrite & txFull) begin
            raw_next[`IFS_BIT_TX_OVER] = 1'b1;
        end
        if (rxByte & rxFull) begin
            raw_next[`IFS_BIT_RX_OVER] = 1'b1;
        end
        if (dataCmdRead & rxEmpty) begin
            raw_next[`IFS_BIT_RX_UNDER] = 1'b1;
        end
        // Level flags track the FIFOs; receive threshold n means n plus one entries, transmit threshold n means n or fewer
        raw_next[`IFS_BIT_RX_FULL] = ctrlEnable &
            (rxLevel >= ({1'b0, rxThreshold_reg} + 6'h01));
        // Top setting stands for a full FIFO of 32, not for 31 entries
        raw_next[`IFS_BIT_TX_EMPTY] = internalEnable & ((txLevel <= {1'b0, txThreshold_reg}) |
            (txThreshold_reg == `IFS_THRESHOLD_MAX));
    end

    // Status flags, combined interrupt and abort cause clear pulse
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rawIrqStatus <= 5'h00;
            irqCombined <= 1'b0;
            abortCauseClear <= 1'b0;
        end else begin
            rawIrqStatus <= raw_next;
            irqCombined <= |(raw_next & irqMask);
            abortCauseClear <= clearAll & ~abortCauseKeep;
        end
    end

    // Reserved bits 15:5 only steer saturation and are never stored
    // Threshold registers; only the five-bit field is kept
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxThreshold_reg <= `IFS_THRESHOLD_RESET;
            txThreshold_reg <= `IFS_THRESHOLD_RESET;
        end else begin
            if (wrDone & hitRxTl) begin
                rxThreshold_reg <= thrWrite;
            end
            if (wrDone & hitTxTl) begin
                txThreshold_reg <= thrWrite;
            end
        end
    end

    // Limitation: writes to the raw status and clear-all addresses are ignored
    // APB slave: one wait state so read data comes from a flop
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (psel & penable & ~pready) begin
            pready <= 1'b1;
            pslverr <= ~(hitRaw | hitRxTl | hitTxTl | hitClr);
            if (pwrite | hitClr) begin
                prdata <= 32'h00000000; // Clear-all reads as zero
            end else if (hitRaw) begin
                prdata <= {27'h0000000, rawIrqStatus};
            end else if (hitRxTl) begin
                prdata <= {27'h0000000, rxThreshold_reg};
            end else if (hitTxTl) begin
                prdata <= {27'h0000000, txThreshold_reg};
            end else begin
                prdata <= 32'h00000000;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // ifs_status

// *** sim/ifs_status_chk.sv ***
// Port-level assertions for the FIFO status block
`timescale 1ns/1ns
`include "ifs_map.vh"
module ifs_status_chk (
    input wire clk_sys, resetn, psel, penable, pwrite, pready, // Clock, reset, bus
    input wire [31:0] paddr, // Bus address
    input wire ctrlEnable, internalEnable, dataCmdWrite, dataCmdRead, rxByte, // Events
    input wire abortCauseKeep, abortCauseClear, irqCombined, // Abort and interrupt
    input wire [4:0] irqMask, rawIrqStatus // Mask and raw flags
);
    // Clear-all read completes in the ready cycle
    wire clrRd = psel && penable && pready && !pwrite && paddr == `IFS_CLEAR_ALL_IRQS_ADDR;
    wire noSet = !rxByte && !dataCmdRead && !dataCmdWrite; // A set event wins over clears
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_txover_cause: assert property ($rose(rawIrqStatus[3]) |-> $past(dataCmdWrite))
        else $error("tx overflow without write");
    a_rxover_cause: assert property ($rose(rawIrqStatus[1]) |-> $past(rxByte))
        else $error("rx overflow without byte");
    a_under_cause: assert property ($rose(rawIrqStatus[0]) |-> $past(dataCmdRead))
        else $error("underflow without read");
    a_flag_hold: assert property (internalEnable && !clrRd
        |=> (rawIrqStatus & $past(rawIrqStatus) & 5'h0b) == ($past(rawIrqStatus) & 5'h0b))
        else $error("sticky flag lost");
    a_disable_clear: assert property ((!internalEnable && noSet) [*2]
        |=> (rawIrqStatus & 5'h0b) == 5'h00) else $error("flags kept when idle");
    a_rxfull_drop: assert property (!ctrlEnable |=> !rawIrqStatus[2])
        else $error("rx threshold flag while disabled");
    a_clear_flags: assert property (clrRd && noSet
        |=> (rawIrqStatus & 5'h0b) == 5'h00) else $error("clear-all left flags");
    a_abort_keep: assert property (abortCauseClear
        |-> $past(clrRd) && !$past(abortCauseKeep)) else $error("abort clear misplaced");
    a_abort_pulse: assert property (clrRd && !abortCauseKeep |=> abortCauseClear)
        else $error("abort clear missing");
    a_irq_comb: assert property (irqCombined == |(rawIrqStatus & $past(irqMask)))
        else $error("combined interrupt wrong");
    c_clear: cover property (clrRd);
    c_rxover: cover property ($rose(rawIrqStatus[1]));
    c_idle: cover property ($fell(internalEnable));
endmodule // ifs_status_chk
bind ifs_status ifs_status_chk ifs_status_chk_inst (.*);

// *** sim/ifs_engine_model.sv ***
// Far-side engine model: received bytes and transmit takes
`timescale 1ns/1ns
module ifs_engine_model (
    input wire clk_sys, // System clock
    output reg rxByte = 1'b0, // Byte arrived
    output reg txPop = 1'b0 // Entry taken
);
    // Gap sets prompt or slow pace; every byte is delivered, even at full
    task run(input rx, input integer n, input integer gap);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1) begin
                @(negedge clk_sys);
                {rxByte, txPop} = rx ? 2'b10 : 2'b01;
                @(negedge clk_sys);
                {rxByte, txPop} = 2'b00;
                repeat (gap) @(negedge clk_sys);
            end
        end
    endtask
endmodule // ifs_engine_model

// *** sim/tb_ifs_status.sv ***
// Self-checking bench for the FIFO status block
`timescale 1ns/1ns
`include "ifs_map.vh"
module tb_ifs_status;
    reg clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, rdErr;
    reg [31:0] paddr = 0, pwdata = 0, rd;
    reg ctrlEnable = 0, engineActive = 0, dataCmdWrite = 0, dataCmdRead = 0, abortCauseKeep = 0;
    reg [4:0] irqMask = 5'h1f;
    reg [96:0] rows [0:5];
    wire [31:0] prdata;
    wire pready, pslverr, txPop, rxByte, internalEnable, abortCauseClear, irqCombined;
    wire [4:0] rawIrqStatus;
    integer err_total = 0, n_tests = 0, i, w;
    ifs_status ifs_status_inst (.*);
    ifs_engine_model eng (.clk_sys(clk_sys), .rxByte(rxByte), .txPop(txPop));
    initial forever #25 clk_sys = ~clk_sys;
    task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("unexpected %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // Bus cycle held until ready; the wait is bounded so a hang ends the run
    task bus(input wr, input [31:0] a, input [31:0] d);
        begin
            @(negedge clk_sys);
            {psel, pwrite, paddr, pwdata} = {1'b1, wr, a, d};
            @(negedge clk_sys);
            penable = 1;
            for (w = 0; w < 8 && pready !== 1'b1; w = w + 1) @(negedge clk_sys);
            if (w == 8) begin
                err_total = err_total + 1;
                finish_test;
            end
            {rd, rdErr} = {prdata, pslverr};
            @(negedge clk_sys);
            {psel, penable} = 2'b00;
        end
    endtask
    // Command port pulses from the processor side
    task cmd(input wr, input integer n);
        begin
            for (w = 0; w < n; w = w + 1) begin
                @(negedge clk_sys);
                {dataCmdWrite, dataCmdRead} = wr ? 2'b10 : 2'b01;
                @(negedge clk_sys);
                {dataCmdWrite, dataCmdRead} = 2'b00;
            end
            @(negedge clk_sys);
        end
    endtask
    initial begin
        // Address, write data, read back, error expected
        rows[0] = {`IFS_RX_FIFO_THRESHOLD_ADDR, 32'h5, 32'h5, 1'b0};
        rows[1] = {`IFS_RX_FIFO_THRESHOLD_ADDR, 32'h20, 32'h1f, 1'b0};
        rows[2] = {`IFS_TX_FIFO_THRESHOLD_ADDR, 32'h100, 32'h1f, 1'b0};
        rows[3] = {`IFS_TX_FIFO_THRESHOLD_ADDR, 32'h3, 32'h3, 1'b0};
        rows[4] = {`IFS_RX_FIFO_THRESHOLD_ADDR, 32'h2, 32'h2, 1'b0};
        rows[5] = {32'h50001400, 32'h1, 32'h0, 1'b1};
        repeat (2) @(negedge clk_sys);
        resetn = 1;
        for (i = 0; i < 3; i = i + 1) begin
            bus(0, `IFS_RAW_IRQ_STATUS_ADDR + 4 * i, 0);
            chk(rd, 0, "reset");
        end
        $display("reset test done");
        ctrlEnable = 1;
        for (i = 0; i < 6; i = i + 1) begin
            bus(1, rows[i][96:65], rows[i][64:33]);
            bus(0, rows[i][96:65], 0);
            if (rows[i][0]) chk(rdErr, 1, "slverr"); else chk(rd, rows[i][32:1], "thr");
        end
        $display("register rows done");
        // Threshold 2 fires at three entries, drops below
        eng.run(1, 2, 1);
        chk(rawIrqStatus[2], 0, "rxfull");
        eng.run(1, 1, 1);
        bus(0, `IFS_RAW_IRQ_STATUS_ADDR, 0);
        chk(rd, 32'h14, "raw");
        cmd(0, 1);
        chk(rawIrqStatus[2], 0, "rxfull");
        // Fill to 32 entries, then one byte too many
        eng.run(1, 30, 0);
        chk(rawIrqStatus[1], 0, "rxover");
        eng.run(1, 1, 1);
        chk({irqCombined, rawIrqStatus[1]}, 3, "rxover");
        // Transmit level crosses threshold 3, then overflows at 32
        cmd(1, 4);
        chk(rawIrqStatus[4], 0, "txempty");
        eng.run(0, 1, 1);
        chk(rawIrqStatus[4], 1, "txempty");
        cmd(1, 29);
        chk(rawIrqStatus[3], 0, "txover");
        cmd(1, 1);
        chk(rawIrqStatus[3], 1, "txover");
        bus(1, `IFS_TX_FIFO_THRESHOLD_ADDR, 32'h1f);
        @(negedge clk_sys);
        chk(rawIrqStatus[4], 1, "txtop");
        $display("level tests done");
        // Disable while the engine is busy, then let it go idle
        engineActive = 1;
        ctrlEnable = 0;
        repeat (3) @(negedge clk_sys);
        chk({internalEnable, rawIrqStatus}, 6'h3a, "busy");
        engineActive = 0;
        repeat (3) @(negedge clk_sys);
        chk({internalEnable, rawIrqStatus}, 0, "idle");
        ctrlEnable = 1;
        repeat (2) @(negedge clk_sys);
        cmd(0, 1);
        chk(rawIrqStatus, 5'h11, "under");
        irqMask = 5'h0e;
        @(negedge clk_sys);
        chk(irqCombined, 0, "mask");
        irqMask = 5'h1f;
        // Clear-all read, then with the abort exception held
        bus(0, `IFS_CLEAR_ALL_IRQS_ADDR, 0);
        chk({rd[25:0], abortCauseClear, rawIrqStatus}, 6'h30, "clrall");
        abortCauseKeep = 1;
        bus(0, `IFS_CLEAR_ALL_IRQS_ADDR, 0);
        chk(abortCauseClear, 0, "keep");
        $display("clear tests done");
        // Reset in mid-run drops flags, enable and thresholds at once
        resetn = 0;
        @(negedge clk_sys);
        chk({internalEnable, irqCombined, rawIrqStatus}, 0, "midrst");
        resetn = 1;
        bus(0, `IFS_RX_FIFO_THRESHOLD_ADDR, 0);
        chk(rd, 0, "midrst");
        $display("mid-run reset done");
        finish_test;
    end
endmodule // tb_ifs_status
